//--- core/spc_proc_call.sv
// spc_proc_call: procedure call, exit and free-list search sequencer.
// assumes segment directory, transfer tables and link headers in main memory
// are kept by the operating system; traps are serviced outside this block.
`timescale 1ns/100ps

module spc_proc_call #(
  parameter int LINKED_LIST_SEARCH_INSTR_MAX = spc_pkg::LINKED_LIST_SEARCH_INSTR_MAX_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_cmd_valid,
  input  wire logic [1:0]  i_cmd_op,
  input  wire logic [15:0] i_cmd_arg,
  input  wire logic [15:0] i_cmd_size,
  input  wire logic        i_user_mode,
  input  wire logic        i_advance,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [15:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_trap,
  output logic [2:0]       o_trap_code,
  output logic [7:0]       o_absent_seg,
  output logic [15:0]      o_result,
  output logic [15:0]      o_pb,
  output logic [15:0]      o_pl,
  output logic [15:0]      o_p,
  output logic [15:0]      o_sp,
  output logic [15:0]      o_status
);

  initial begin
    if (LINKED_LIST_SEARCH_INSTR_MAX < 1 || LINKED_LIST_SEARCH_INSTR_MAX > 65535) begin
      $error("LINKED_LIST_SEARCH_INSTR_MAX out of range");
    end
  end

  typedef enum logic [4:0] {
    S_IDLE, S_LEN, S_LABEL, S_TOS, S_DECODE, S_DIRPTR, S_DIRLEN, S_DIR0, S_DIR1,
    S_TGTLEN, S_TGT, S_PUSHR, S_PUSHS, S_POPS, S_POPR, S_LLHDR, S_LLTRL, S_LLFWD, S_FIN
  } spc_state_t;

  spc_state_t        state;
  spc_mem_if         mif ();
  logic              pend;
  logic              exiting;
  logic [15:0]       tsp;
  logic [15:0]       npb;
  logic [15:0]       npl;
  logic [15:0]       label;
  logic [7:0]        seg;
  logic [6:0]        transfer_table;
  logic [15:0]       dir_ptr;
  logic [14:0]       seg_len;
  logic [13:0]       tgt_off;
  logic [15:0]       sta_save;
  logic [15:0]       ret;
  logic [15:0]       node;
  logic [15:0]       blk_size;
  logic [15:0]       steps;
  logic [2:0]        fault;
  logic              is_mem;
  logic              next_we;
  logic [15:0]       next_addr;
  logic [15:0]       next_wdata;
  logic [15:0]       rd;

  assign rd = mif.rdata;

  // ------------------------------------------------------------
  // address helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] stt_addr(input logic [15:0] limit, input logic [15:0] n);
    stt_addr = limit - n;
  endfunction

  function automatic logic [15:0] dir_addr(input logic [15:0] base, input logic [7:0] s, input logic w);
    logic [15:0] idx;
    idx = {8'h00, s} << spc_pkg::DIR_SHIFT;
    dir_addr = base + idx + {15'h0000, w};
  endfunction

  function automatic logic [15:0] pl_word(input logic [15:0] n);
    pl_word = stt_addr(o_pl, n);
  endfunction

  spc_mem_port u_port (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .mif         (mif.engine),
    .i_mem_ack   (i_mem_ack),
    .i_mem_rdata (i_mem_rdata),
    .o_mem_req   (o_mem_req),
    .o_mem_we    (o_mem_we),
    .o_mem_addr  (o_mem_addr),
    .o_mem_wdata (o_mem_wdata)
  );

  // ------------------------------------------------------------
  // memory request per state
  // ------------------------------------------------------------
  always_comb begin
    is_mem     = 1'b1;
    next_we    = 1'b0;
    next_wdata = 16'h0000;
    next_addr  = 16'h0000;
    case (state)
      S_LEN:    next_addr = pl_word(16'h0000);
      S_LABEL:  next_addr = stt_addr(o_pl, i_cmd_arg);
      S_TOS:    next_addr = tsp;
      S_DIRPTR: next_addr = spc_pkg::DIR_PTR_LOC;
      S_DIRLEN: next_addr = dir_addr(dir_ptr, 8'h00, 1'b0);
      S_DIR0:   next_addr = dir_addr(dir_ptr, seg, 1'b0);
      S_DIR1:   next_addr = dir_addr(dir_ptr, seg, 1'b1);
      S_TGTLEN: next_addr = stt_addr(npl, 16'h0000);
      S_TGT:    next_addr = stt_addr(npl, {9'h000, transfer_table});
      S_PUSHR: begin
        next_we    = 1'b1;
        next_addr  = tsp + spc_pkg::ONE;
        next_wdata = o_p - o_pb + spc_pkg::ONE;
      end
      S_PUSHS: begin
        next_we    = 1'b1;
        next_addr  = tsp + 16'h0002;
        next_wdata = o_status;
      end
      S_POPS:   next_addr = o_sp;
      S_POPR:   next_addr = o_sp - spc_pkg::ONE;
      S_LLHDR:  next_addr = node + spc_pkg::HDR_SIZE;
      S_LLTRL:  next_addr = node + blk_size - spc_pkg::ONE;
      S_LLFWD:  next_addr = node + spc_pkg::HDR_FWD;
      default:  is_mem = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // request issue
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pend      <= 1'b0;
      mif.start <= 1'b0;
      mif.we    <= 1'b0;
      mif.addr  <= 16'h0000;
      mif.wdata <= 16'h0000;
    end else begin
      mif.start <= 1'b0;
      if (mif.done) begin
        pend <= 1'b0;
      end else if (is_mem && !pend) begin
        pend      <= 1'b1;
        mif.start <= 1'b1;
        mif.we    <= next_we;
        mif.addr  <= next_addr;
        mif.wdata <= next_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer and architectural registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state        <= S_IDLE;
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
      o_trap       <= 1'b0;
      o_trap_code  <= spc_pkg::TRAP_NONE;
      o_absent_seg <= 8'h00;
      o_result     <= 16'h0000;
      o_pb         <= spc_pkg::PB_RST;
      o_pl         <= spc_pkg::PL_RST;
      o_p          <= spc_pkg::P_RST;
      o_sp         <= spc_pkg::SP_RST;
      o_status     <= spc_pkg::STA_RST;
      fault        <= spc_pkg::TRAP_NONE;
      exiting      <= 1'b0;
      tsp          <= 16'h0000;
      npb          <= 16'h0000;
      npl          <= 16'h0000;
      label        <= 16'h0000;
      seg          <= 8'h00;
      transfer_table          <= 7'h00;
      dir_ptr      <= 16'h0000;
      seg_len      <= 15'h0000;
      tgt_off      <= 14'h0000;
      sta_save     <= 16'h0000;
      ret          <= 16'h0000;
      node         <= 16'h0000;
      blk_size     <= 16'h0000;
      steps        <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      o_trap <= 1'b0;
      case (state)
        S_IDLE: begin
          fault   <= spc_pkg::TRAP_NONE;
          exiting <= 1'b0;
          tsp     <= o_sp;
          if (i_cmd_valid && i_cmd_op == spc_pkg::OP_CALL) begin
            o_busy <= 1'b1;
            state  <= S_LEN;
          end else if (i_cmd_valid && i_cmd_op == spc_pkg::OP_EXIT) begin
            o_busy <= 1'b1;
            state  <= S_POPS;
          end else if (i_cmd_valid && i_cmd_op == spc_pkg::OP_LINKED_LIST_SEARCH_INSTR) begin
            o_busy <= 1'b1;
            node   <= i_cmd_arg;
            steps  <= 16'h0000;
            state  <= S_LLHDR;
          end else if (i_advance && o_p < o_pl) begin
            o_p <= o_p + spc_pkg::ONE;
          end
        end
        S_LEN: if (mif.done) begin
          if (i_cmd_arg > {8'h00, rd[spc_pkg::STT_LEN_MSB:0]}) begin
            fault <= spc_pkg::TRAP_BOUNDS;
            state <= S_FIN;
          end else if (i_cmd_arg == 16'h0000) begin
            state <= S_TOS;
          end else begin
            state <= S_LABEL;
          end
        end
        S_TOS: if (mif.done) begin
          label <= rd;
          tsp   <= tsp - spc_pkg::ONE;
          state <= S_DECODE;
        end
        S_LABEL: if (mif.done) begin
          label <= rd;
          state <= S_DECODE;
        end
        S_DECODE: begin
          if (label[spc_pkg::LBL_EXT_BIT]) begin
            seg   <= label[spc_pkg::EXT_SEG_MSB:0];
            transfer_table   <= label[spc_pkg::EXT_STT_MSB:spc_pkg::EXT_STT_LSB];
            state <= S_DIRPTR;
          end else begin
            npb     <= o_pb;
            npl     <= o_pl;
            tgt_off <= label[spc_pkg::LBL_OFF_MSB:0];
            state   <= S_PUSHR;
          end
        end
        S_DIRPTR: if (mif.done) begin
          dir_ptr <= rd;
          state   <= S_DIRLEN;
        end
        S_DIRLEN: if (mif.done) begin
          if (seg == 8'h00 || {8'h00, seg} > rd) begin
            fault <= spc_pkg::TRAP_BADSEG;
            state <= S_FIN;
          end else begin
            state <= S_DIR0;
          end
        end
        S_DIR0: if (mif.done) begin
          if (rd[spc_pkg::DIR_ABSENT]) begin
            o_absent_seg <= seg;
            fault        <= spc_pkg::TRAP_ABSENT;
            state        <= S_FIN;
          end else begin
            seg_len <= rd[spc_pkg::DIR_LEN_MSB:0];
            state   <= S_DIR1;
          end
        end
        S_DIR1: if (mif.done) begin
          if (exiting) begin
            o_pb     <= rd;
            o_pl     <= rd + {1'b0, seg_len} - spc_pkg::ONE;
            o_p      <= rd + ret;
            o_status <= sta_save;
            o_sp     <= o_sp - 16'h0002;
            state    <= S_FIN;
          end else begin
            npb   <= rd;
            npl   <= rd + {1'b0, seg_len} - spc_pkg::ONE;
            state <= S_TGTLEN;
          end
        end
        S_TGTLEN: if (mif.done) begin
          if ({9'h000, transfer_table} > {8'h00, rd[spc_pkg::STT_LEN_MSB:0]}) begin
            fault <= spc_pkg::TRAP_BOUNDS;
            state <= S_FIN;
          end else if (transfer_table == 7'h00) begin
            if (rd[spc_pkg::STT_U_BIT] && i_user_mode) begin
              fault <= spc_pkg::TRAP_UNCALL;
              state <= S_FIN;
            end else begin
              tgt_off <= 14'h0000;
              state   <= S_PUSHR;
            end
          end else begin
            state <= S_TGT;
          end
        end
        S_TGT: if (mif.done) begin
          if (rd[spc_pkg::LBL_U_BIT] && i_user_mode) begin
            fault <= spc_pkg::TRAP_UNCALL;
            state <= S_FIN;
          end else begin
            tgt_off <= rd[spc_pkg::LBL_OFF_MSB:0];
            state   <= S_PUSHR;
          end
        end
        S_PUSHR: if (mif.done) begin
          state <= S_PUSHS;
        end
        S_PUSHS: if (mif.done) begin
          o_pb  <= npb;
          o_pl  <= npl;
          o_p   <= npb + {2'b00, tgt_off};
          o_sp  <= tsp + 16'h0002;
          if (label[spc_pkg::LBL_EXT_BIT]) begin
            o_status[spc_pkg::STA_SEG_MSB:0] <= seg;
          end
          state <= S_FIN;
        end
        S_POPS: if (mif.done) begin
          sta_save <= rd;
          seg      <= rd[spc_pkg::STA_SEG_MSB:0];
          state    <= S_POPR;
        end
        S_POPR: if (mif.done) begin
          ret     <= rd;
          exiting <= 1'b1;
          state   <= S_DIRPTR;
        end
        S_LLHDR: if (mif.done) begin
          blk_size <= rd;
          state    <= S_LLTRL;
        end
        S_LLTRL: if (mif.done) begin
          if (!rd[spc_pkg::TRL_ASSIGNED] && blk_size >= i_cmd_size) begin
            o_result <= node;
            state    <= S_FIN;
          end else begin
            state <= S_LLFWD;
          end
        end
        S_LLFWD: if (mif.done) begin
          if (rd == 16'h0000 || steps == 16'(LINKED_LIST_SEARCH_INSTR_MAX - 1)) begin
            o_result <= 16'h0000;
            state    <= S_FIN;
          end else begin
            node  <= rd;
            steps <= steps + spc_pkg::ONE;
            state <= S_LLHDR;
          end
        end
        S_FIN: begin
          o_busy      <= 1'b0;
          o_done      <= 1'b1;
          o_trap      <= fault != spc_pkg::TRAP_NONE;
          o_trap_code <= fault;
          state       <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

//--- core/spc_pkg.sv
// spc_pkg: word formats, fixed locations, reset values and enums for the
// segment procedure call unit.
// assumes 16-bit words and word-addressed main memory.
package spc_pkg;

  // ------------------------------------------------------------
  // fixed memory and table layout
  // ------------------------------------------------------------
  localparam int          WORD_W        = 16;
  localparam logic [15:0] DIR_PTR_LOC   = 16'h0000;
  localparam int          DIR_SHIFT     = 1;
  localparam logic [15:0] ONE           = 16'h0001;

  // ------------------------------------------------------------
  // label, transfer table and directory word fields
  // ------------------------------------------------------------
  localparam int LBL_EXT_BIT   = 15;
  localparam int LBL_U_BIT     = 14;
  localparam int LBL_OFF_MSB   = 13;
  localparam int EXT_STT_MSB   = 14;
  localparam int EXT_STT_LSB   = 8;
  localparam int EXT_SEG_MSB   = 7;
  localparam int STT_LEN_MSB   = 7;
  localparam int STT_U_BIT     = 15;
  localparam int DIR_ABSENT    = 15;
  localparam int DIR_LEN_MSB   = 14;
  localparam int STA_SEG_MSB   = 7;

  // ------------------------------------------------------------
  // memory segment link header and trailer
  // ------------------------------------------------------------
  localparam logic [15:0] HDR_WORDS     = 16'h0008;
  localparam logic [15:0] HDR_FWD       = 16'h0000;
  localparam logic [15:0] HDR_BWD       = 16'h0001;
  localparam logic [15:0] HDR_SIZE      = 16'h0002;
  localparam int          TRL_ASSIGNED  = 15;

  // ------------------------------------------------------------
  // reset values and default free-list search step limit
  // ------------------------------------------------------------
  localparam logic [15:0] PB_RST        = 16'h0000;
  localparam logic [15:0] PL_RST        = 16'h0000;
  localparam logic [15:0] P_RST         = 16'h0000;
  localparam logic [15:0] SP_RST        = 16'h0000;
  localparam logic [15:0] STA_RST       = 16'h0000;
  localparam int          LINKED_LIST_SEARCH_INSTR_MAX_DEF  = 255;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_CALL,
    OP_EXIT,
    OP_LINKED_LIST_SEARCH_INSTR
  } spc_op_t;

  typedef enum logic [2:0] {
    TRAP_NONE,
    TRAP_BOUNDS,
    TRAP_UNCALL,
    TRAP_ABSENT,
    TRAP_BADSEG
  } spc_trap_t;

endpackage

//--- core/spc_mem_if.sv
// spc_mem_if: single-word memory request path between the sequencer and
// the memory port.
// assumes one request outstanding at a time.
`timescale 1ns/100ps
interface spc_mem_if;
  logic        start;
  logic        we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done;

  modport master (output start, output we, output addr, output wdata, input rdata, input done);
  modport engine (input start, input we, input addr, input wdata, output rdata, output done);
endinterface

//--- core/spc_mem_port.sv
// spc_mem_port: holds one memory request on the pins until acknowledged.
// assumes main memory answers with a one-cycle i_mem_ack, read data valid then.
`timescale 1ns/100ps
module spc_mem_port (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  spc_mem_if.engine        mif,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [15:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata
);

  // ------------------------------------------------------------
  // request hold
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 16'h0000;
    end else if (mif.start && !o_mem_req) begin
      o_mem_req   <= 1'b1;
      o_mem_we    <= mif.we;
      o_mem_addr  <= mif.addr;
      o_mem_wdata <= mif.wdata;
    end else if (o_mem_req && i_mem_ack) begin
      o_mem_req <= 1'b0;
      o_mem_we  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // completion
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mif.done  <= 1'b0;
      mif.rdata <= 16'h0000;
    end else begin
      mif.done <= o_mem_req && i_mem_ack;
      if (o_mem_req && i_mem_ack) begin
        mif.rdata <= i_mem_rdata;
      end
    end
  end

endmodule

//--- bench/spc_proc_call_assertions.sv
// spc_proc_call_assertions: port-level checks on the procedure call unit.
// assumes it is bound into spc_proc_call and sees only that module's ports.
`timescale 1ns/100ps
module spc_proc_call_assertions #(
  parameter int LINKED_LIST_SEARCH_INSTR_MAX = spc_pkg::LINKED_LIST_SEARCH_INSTR_MAX_DEF
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_cmd_valid,
  input wire logic [1:0]  i_cmd_op,
  input wire logic [15:0] i_cmd_arg,
  input wire logic        i_advance,
  input wire logic        i_mem_ack,
  input wire logic        o_mem_req,
  input wire logic        o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_trap,
  input wire logic [15:0] o_pb,
  input wire logic [15:0] o_pl,
  input wire logic [15:0] o_p,
  input wire logic [15:0] o_sp
);
  // registers as they stood when the running command was taken
  logic [15:0] sv_pb, sv_pl, sv_p, sv_sp, sv_arg;
  logic [1:0]  sv_op;

  always_ff @(posedge i_clk_sys) begin
    if (!o_busy) begin
      sv_pb  <= o_pb;
      sv_pl  <= o_pl;
      sv_p   <= o_p;
      sv_sp  <= o_sp;
      sv_arg <= i_cmd_arg;
      sv_op  <= i_cmd_op;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_req_open;
    o_mem_req && !i_mem_ack;
  endsequence
  sequence s_gap;
    !o_mem_req ##1 !o_mem_req;
  endsequence
  sequence s_good_end;
    o_done && !o_trap;
  endsequence

  a_req_held_stable: assert property (s_req_open |=> o_mem_req && $stable(o_mem_addr)
    && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request changed before ack");
  a_ack_ends_req: assert property (i_mem_ack && o_mem_req |=> s_gap)
    else $error("request not released for two cycles after ack");
  a_done_one_cycle: assert property (o_done |=> !o_done) else $error("done longer than one cycle");
  a_trap_with_done: assert property (o_trap |-> o_done) else $error("trap without done");
  a_cmd_sets_busy: assert property (i_cmd_valid && !o_busy && i_cmd_op != 2'h0 |=> o_busy)
    else $error("command not taken");
  a_idle_no_req: assert property (!o_busy |-> !o_mem_req) else $error("memory request while idle");
  a_trap_keeps_regs: assert property (o_trap |-> o_pb == sv_pb && o_pl == sv_pl
    && o_p == sv_p && o_sp == sv_sp) else $error("aborted call changed registers");
  a_call_pushes_two: assert property (s_good_end and (sv_op == 2'h1 && sv_arg != 16'h0000)
    |-> o_sp == sv_sp + 16'h0002) else $error("call did not push two words");
  a_exit_pops_two: assert property (s_good_end and (sv_op == 2'h2) |-> o_sp == sv_sp - 16'h0002)
    else $error("exit did not pop two words");
  a_advance_step: assert property (!o_busy && !i_cmd_valid && i_advance && o_p < o_pl
    |=> o_p == $past(o_p) + 16'h0001) else $error("fetch pointer did not advance");
endmodule

//--- bench/spc_mem_model.sv
// spc_mem_model: behavioural main memory holding the segment tables.
// assumes word addresses alias into 256 words; acks one request at a time.
`timescale 1ns/100ps
module spc_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] log_a [0:15];
  int          n_log = 0;
  int          wait_n = 0;

  // read data is only valid with ack; otherwise it toggles every cycle
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_n < (i_slow ? 4 : 1)) begin
        wait_n <= wait_n + 1;
      end else begin
        wait_n <= 0;
        o_ack <= 1'b1;
        o_rdata <= mem[i_addr[7:0]];
        if (i_we) begin
          mem[i_addr[7:0]] <= i_wdata;
        end
        if (n_log < 16) begin
          log_a[n_log] <= i_addr;
        end
        n_log <= n_log + 1;
      end
    end
  end
endmodule

//--- bench/tb_spc_proc_call.sv
// tb_spc_proc_call: directed scenarios for the procedure call unit.
// assumes spc_pkg, the memory model and the checker are compiled first.
`timescale 1ns/100ps
module tb_spc_proc_call;
  logic        i_clk_sys, i_rst, cmd_valid, user_mode, advance, slow;
  logic [1:0]  cmd_op;
  logic [15:0] cmd_arg, cmd_size, mem_rdata, mem_addr, mem_wdata;
  logic        mem_ack, mem_req, mem_we, o_busy, o_done, o_trap;
  logic [2:0]  o_trap_code;
  logic [7:0]  o_absent_seg;
  logic [15:0] o_result, o_pb, o_pl, o_p, o_sp, o_status;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // --------------------------------------------------------------
  // memory image: directory, transfer tables, free list
  // --------------------------------------------------------------
  localparam logic [31:0] IMG [0:23] = '{32'h0000_0040, 32'h0040_0003, 32'h0042_0020, 32'h0043_0080,
    32'h0044_0010, 32'h0045_00C0, 32'h0046_8010, 32'h0047_0100, 32'h00FF_8101, 32'h009F_0006,
    32'h009E_0005, 32'h009D_0010, 32'h009C_8102, 32'h009B_8103, 32'h009A_8002, 32'h0099_8004,
    32'h00CF_8001, 32'h00CE_4007, 32'h00D0_00E0, 32'h00D2_000C, 32'h00DB_8003, 32'h00E0_0000,
    32'h00E2_0010, 32'h00EF_0004};
  localparam logic [15:0] EXP_LOG [0:9] = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0040, 16'h0042,
    16'h0043, 16'h009F, 16'h009E, 16'h0001, 16'h0002};

  spc_proc_call #(.LINKED_LIST_SEARCH_INSTR_MAX(4)) spc_proc_call_i (
    .i_clk_sys, .i_rst, .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_arg(cmd_arg),
    .i_cmd_size(cmd_size), .i_user_mode(user_mode), .i_advance(advance), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .o_busy, .o_done, .o_trap, .o_trap_code, .o_absent_seg, .o_result,
    .o_pb, .o_pl, .o_p, .o_sp, .o_status);
  spc_mem_model spc_mem_model_i (
    .i_clk_sys, .i_slow(slow), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
    .i_wdata(mem_wdata), .o_ack(mem_ack), .o_rdata(mem_rdata));

  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regs(input logic [15:0] pb, input logic [15:0] pl, input logic [15:0] p,
                      input logic [15:0] sp);
    chk("code base", pb, o_pb);
    chk("code limit", pl, o_pl);
    chk("fetch pointer", p, o_p);
    chk("stack top", sp, o_sp);
  endtask
  // issues one command and returns at the edge that shows its done pulse
  task automatic run(input logic [1:0] op, input logic [15:0] arg, input logic [2:0] code);
    int k;
    @(posedge i_clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_arg <= arg;
    @(posedge i_clk_sys);
    cmd_valid <= 1'b0;
    for (k = 0; k < 500; k++) begin
      @(posedge i_clk_sys);
      if (o_done === 1'b1) break;
    end
    chk("done", 16'h0001, {15'h0000, o_done});
    chk("trap", {15'h0000, code != 3'h0}, {15'h0000, o_trap});
    chk("trap code", {13'h0000, code}, {13'h0000, o_trap_code});
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_ext_call;
    regs(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    slow <= 1'b1;
    spc_mem_model_i.n_log = 0;
    run(2'h1, 16'h0001, 3'h0);
    for (int i = 0; i < 10; i++) chk("access order", EXP_LOG[i], spc_mem_model_i.log_a[i]);
    regs(16'h0080, 16'h009F, 16'h0085, 16'h0002);
    chk("status", 16'h0001, o_status);
    chk("return word", 16'h0001, spc_mem_model_i.mem[1]);
    slow <= 1'b0;
  endtask
  task automatic t_local_call;
    @(posedge i_clk_sys);
    advance <= 1'b1;
    @(posedge i_clk_sys);
    advance <= 1'b0;
    @(posedge i_clk_sys);
    chk("fetch pointer", 16'h0086, o_p);
    run(2'h1, 16'h0002, 3'h0);
    regs(16'h0080, 16'h009F, 16'h0090, 16'h0004);
    chk("return word", 16'h0007, spc_mem_model_i.mem[3]);
  endtask
  task automatic t_refusals;
    run(2'h1, 16'h0007, 3'h1);
    regs(16'h0080, 16'h009F, 16'h0090, 16'h0004);
    user_mode <= 1'b1;
    run(2'h1, 16'h0003, 3'h2);
    regs(16'h0080, 16'h009F, 16'h0090, 16'h0004);
    user_mode <= 1'b0;
    run(2'h1, 16'h0003, 3'h0);
    regs(16'h00C0, 16'h00CF, 16'h00C7, 16'h0006);
  endtask
  task automatic t_exit_absent;
    slow <= 1'b1;
    run(2'h2, 16'h0000, 3'h0);
    regs(16'h0080, 16'h009F, 16'h0091, 16'h0004);
    chk("status", 16'h0001, o_status);
    slow <= 1'b0;
    run(2'h1, 16'h0004, 3'h3);
    chk("absent segment", 16'h0003, {8'h00, o_absent_seg});
    spc_mem_model_i.mem[4] = 16'h0003;
    run(2'h1, 16'h0000, 3'h0);
    chk("code base", 16'h0080, o_pb);
    chk("fetch pointer", 16'h0083, o_p);
    run(2'h1, 16'h0006, 3'h4);
    regs(16'h0080, 16'h009F, 16'h0083, 16'h0005);
    user_mode <= 1'b1;
    run(2'h1, 16'h0005, 3'h2);
    user_mode <= 1'b0;
    run(2'h1, 16'h0005, 3'h0);
    regs(16'h00C0, 16'h00CF, 16'h00C0, 16'h0007);
  endtask
  task automatic t_search;
    cmd_size <= 16'h000C;
    run(2'h3, 16'h00D0, 3'h0);
    chk("search result", 16'h00E0, o_result);
    cmd_size <= 16'h0020;
    run(2'h3, 16'h00D0, 3'h0);
    chk("search result", 16'h0000, o_result);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    i_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_arg = 16'h0000;
    cmd_size = 16'h0000;
    user_mode = 1'b0;
    advance = 1'b0;
    slow = 1'b0;
    // free list nodes carry link header words and sizes in words
    foreach (IMG[i]) spc_mem_model_i.mem[IMG[i][23:16]] = IMG[i][15:0];
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    t_ext_call();
    t_local_call();
    t_refusals();
    t_exit_absent();
    t_search();
    final_report();
  end
endmodule

bind spc_proc_call spc_proc_call_assertions #(.LINKED_LIST_SEARCH_INSTR_MAX(LINKED_LIST_SEARCH_INSTR_MAX)) spc_proc_call_assertions_i (
  .i_clk_sys, .i_rst, .i_cmd_valid, .i_cmd_op, .i_cmd_arg, .i_advance, .i_mem_ack, .o_mem_req,
  .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_busy, .o_done, .o_trap, .o_pb, .o_pl, .o_p, .o_sp);
